// ---- core/scp_serial_port.sv ----
// three-wire serial slave port with paged registers and an apb status view
// assumes the serial master clocks well below a quarter of MCLK
// Function
// RQ1: slave only; master gives clock and strobe
// RQ2: 25-bit shift register collects each command
// RQ3: msb first; header 101 leads
// RQ4: bit after header: 0 write, 1 read
// RQ5: address decoded from bits 20 to 16
// RQ6: four pages of 32 16-bit registers
// RQ7: page from register 0 bits 11:8; code takes only bits 9:8
// RQ8: write bits sampled on serial clock rise
// RQ9: master changes data on falling edge
// RQ10: write lands on clock rise after strobe
// RQ11: read sends no data; device returns register
// RQ12: master releases data after last address bit
// RQ13: device drives on next rise after release
// RQ14: read data msb first, updated on rise
// RQ15: always sixteen read bits returned
// RQ16: last read bit held until release
// RQ17: strobe ends read; release on next rise
// RQ18: master drives again on following fall
// RQ19: master samples read bit before falling edge
// RQ20: reset held 2 ms after supplies
// RQ21: port works while chip enable low
// RQ22: header 24:22, rw 21, address 20:16, data 15:0
`timescale 1ns/1ps
module scp_serial_port
    import scp_pkg::*;
#(
    parameter int APB_AW = 12
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CTRL_SERIAL_CLOCK,
    input wire logic CTRL_LOAD_STROBE,
    input wire logic CTRL_SERIAL_DATA_I,
    output logic CTRL_SERIAL_DATA_O,
    output logic CTRL_SERIAL_DATA_OE,
    input wire logic CHIP_ENABLE
);
    import scp_pkg::*;

    localparam int IDX_W = $clog2(SCP_PAGES * SCP_REGS_PER_PAGE);
    localparam int PG_W = $clog2(SCP_PAGES);

    typedef struct packed {
        scp_state_t st;
        logic [SCP_FRAME_BITS-1:0] sh;
        logic [4:0] cnt;
        logic hdr_bad;
        logic load_pend;
        logic [SCP_REG_WIDTH-1:0] tx;
        logic [4:0] tx_cnt;
        logic sdo;
        logic sdoe;
        logic prev_clk;
        logic prev_stb;
        logic port_en;
        logic hdr_err;
        logic [4:0] last_addr;
        logic [15:0] frames;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic wr_en;
        logic [IDX_W-1:0] wr_idx;
        logic [SCP_REG_WIDTH-1:0] wr_data;
    } scp_port_t;

    scp_port_t q;
    scp_port_t d;

    logic clk_s;
    logic stb_s;
    logic din_s;
    logic ce_s;
    logic [SCP_REG_WIDTH-1:0] rd_data;
    logic [PG_W-1:0] page;
    logic [IDX_W-1:0] rd_idx;

    if (APB_AW < 4 || APB_AW > 12)
    begin : g_chk
        $error("scp_serial_port: apb address width out of range");
    end

    // register index: address 0 is shared by all pages
    function automatic logic [IDX_W-1:0] reg_index(
        input logic [4:0] addr,
        input logic [PG_W-1:0] pg
    );
        if (addr == SCP_PAGE_REG)
        begin
            return '0;
        end
        return {pg, addr}; // RQ7
    endfunction

    // all serial pins and chip enable come from outside this domain
    scp_sync #(
        .W(4)
    ) u_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .din({CTRL_SERIAL_CLOCK, CTRL_LOAD_STROBE, CTRL_SERIAL_DATA_I, CHIP_ENABLE}),
        .dout({clk_s, stb_s, din_s, ce_s}) // RQ1
    );

    // paged register storage
    scp_reg_array #(
        .PAGES(SCP_PAGES),
        .REGS(SCP_REGS_PER_PAGE),
        .WIDTH(SCP_REG_WIDTH)
    ) u_regs (
        .clk(MCLK),
        .rst_n(RST_N),
        .wr_en(q.wr_en),
        .wr_idx(q.wr_idx),
        .wr_data(q.wr_data),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .page(page)
    );

    // read index follows the captured address field
    assign rd_idx = reg_index(q.sh[4:0], page); // RQ5

    // next-state logic for bus slave and serial engine
    always_comb
    begin
        logic [SCP_FRAME_BITS-1:0] sh_n;
        logic [4:0] cnt_n;
        logic bad_n;
        logic [31:0] rd;
        sh_n = '0;
        cnt_n = '0;
        bad_n = 1'b0;
        rd = '0;
        d = q;
        d.wr_en = 1'b0;
        d.prev_clk = clk_s;
        d.prev_stb = stb_s;

        // apb: one wait state, answer registered
        d.pready = PSEL & PENABLE & ~q.pready;
        if (PSEL && PENABLE && !q.pready)
        begin
            d.pslverr = 1'b0;
            if (PADDR == SCP_OFS_CTRL[APB_AW-1:0])
            begin
                rd[SCP_CTRL_PORT_EN_BIT] = q.port_en;
            end
            else if (PADDR == SCP_OFS_STATUS[APB_AW-1:0])
            begin
                rd[SCP_STS_BUSY_BIT] = (q.st != SCP_ST_IDLE);
                rd[SCP_STS_HDR_ERR_BIT] = q.hdr_err;
                rd[SCP_STS_CHIP_EN_BIT] = ce_s; // RQ21
                rd[SCP_STS_ADDR_LSB +: 5] = q.last_addr;
                rd[SCP_STS_PAGE_LSB +: PG_W] = page;
            end
            else if (PADDR == SCP_OFS_FRAMES[APB_AW-1:0])
            begin
                rd[15:0] = q.frames;
            end
            else
            begin
                d.pslverr = 1'b1;
            end
            d.prdata = rd;
        end
        else
        begin
            // error flag stands only with its pready pulse
            d.pslverr = 1'b0;
        end

        // apb writes take effect on the completing edge
        if (PSEL && PENABLE && q.pready && PWRITE && !q.pslverr)
        begin
            if (PADDR == SCP_OFS_CTRL[APB_AW-1:0])
            begin
                d.port_en = PWDATA[SCP_CTRL_PORT_EN_BIT];
            end
            else if (PADDR == SCP_OFS_STATUS[APB_AW-1:0])
            begin
                if (PWDATA[SCP_STS_HDR_ERR_BIT])
                begin
                    d.hdr_err = 1'b0;
                end
            end
        end

        // strobe rise arms the load or release
        if (stb_s && !q.prev_stb)
        begin
            d.load_pend = 1'b1;
        end

        // serial clock rising edge
        if (clk_s && !q.prev_clk)
        begin
            if (q.load_pend)
            begin
                // complete write frame goes to its register
                if (q.st == SCP_ST_SHIFT && q.cnt == SCP_FRAME_BITS && !q.hdr_bad
                    && !q.sh[SCP_RW_BIT] && q.port_en)
                begin
                    d.wr_en = 1'b1; // RQ10
                    d.wr_idx = reg_index(q.sh[SCP_ADDR_MSB:SCP_ADDR_LSB], page);
                    d.wr_data = q.sh[SCP_DATA_MSB:0]; // RQ22
                    d.last_addr = q.sh[SCP_ADDR_MSB:SCP_ADDR_LSB];
                    d.frames = q.frames + 16'h0001;
                end
                if (q.st == SCP_ST_TURN || q.st == SCP_ST_SEND)
                begin
                    d.frames = q.frames + 16'h0001;
                end
                d.sdoe = 1'b0; // RQ17
                d.st = SCP_ST_IDLE;
                d.cnt = '0;
                d.hdr_bad = 1'b0;
                d.load_pend = 1'b0;
            end
            else
            begin
                case (q.st)
                    SCP_ST_IDLE, SCP_ST_SHIFT:
                    begin
                        // shift in msb first while the frame is not full
                        sh_n = {q.sh[SCP_FRAME_BITS-2:0], din_s}; // RQ8
                        cnt_n = q.cnt;
                        bad_n = q.hdr_bad;
                        if (q.cnt < SCP_FRAME_BITS)
                        begin
                            cnt_n = q.cnt + 5'h01;
                            d.sh = sh_n; // RQ2
                        end
                        else
                        begin
                            sh_n = q.sh;
                        end
                        if (cnt_n == SCP_HDR_BITS && q.cnt != cnt_n
                            && sh_n[2:0] != SCP_HEADER)
                        begin
                            bad_n = 1'b1; // RQ3
                            d.hdr_err = 1'b1;
                        end
                        d.cnt = cnt_n;
                        d.hdr_bad = bad_n;
                        d.st = SCP_ST_SHIFT;
                        // read command: take the line after the last address bit
                        if (cnt_n == SCP_READ_CMD_BITS && q.cnt != cnt_n && sh_n[5]
                            && !bad_n && q.port_en)
                        begin
                            d.st = SCP_ST_TURN; // RQ4
                            d.last_addr = sh_n[4:0]; // RQ11
                        end
                    end
                    SCP_ST_TURN:
                    begin
                        // master let go on the last fall; drive the msb now
                        d.sdoe = 1'b1; // RQ13
                        d.sdo = rd_data[SCP_REG_WIDTH-1]; // RQ12
                        d.tx = {rd_data[SCP_REG_WIDTH-2:0], 1'b0};
                        d.tx_cnt = 5'h01;
                        d.st = SCP_ST_SEND;
                    end
                    SCP_ST_SEND:
                    begin
                        // next bit each rise; after sixteen the last one stays
                        if (q.tx_cnt < SCP_DATA_BITS)
                        begin
                            d.sdo = q.tx[SCP_REG_WIDTH-1]; // RQ14
                            d.tx = {q.tx[SCP_REG_WIDTH-2:0], 1'b0};
                            d.tx_cnt = q.tx_cnt + 5'h01; // RQ15
                        end
                        else
                        begin
                            d.sdo = q.sdo; // RQ16
                        end
                    end
                    default:
                    begin
                        d.st = SCP_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // state register, synchronous reset
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            q <= '0;
            q.st <= SCP_ST_IDLE;
            q.port_en <= SCP_CTRL_PORT_EN_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from flops; sdoe low hands the line back, RQ18
    assign PRDATA = q.prdata;
    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign CTRL_SERIAL_DATA_O = q.sdo;
    assign CTRL_SERIAL_DATA_OE = q.sdoe;
endmodule

// ---- core/scp_pkg.sv ----
// constants and types for the serial control register port
// assumes a 50 MHz system clock and an APB register bus
package scp_pkg;

    // serial frame layout, msb first
    localparam logic [4:0] SCP_FRAME_BITS = 5'h19;
    localparam logic [4:0] SCP_HDR_BITS = 5'h03;
    localparam logic [4:0] SCP_READ_CMD_BITS = 5'h09;
    localparam logic [4:0] SCP_DATA_BITS = 5'h10;
    localparam logic [2:0] SCP_HEADER = 3'h5;
    localparam int SCP_HDR_LSB = 22;
    localparam int SCP_RW_BIT = 21;
    localparam int SCP_ADDR_MSB = 20;
    localparam int SCP_ADDR_LSB = 16;
    localparam int SCP_DATA_MSB = 15;

    // register space
    localparam int SCP_PAGES = 4;
    localparam int SCP_REGS_PER_PAGE = 32;
    localparam int SCP_REG_WIDTH = 16;
    localparam logic [4:0] SCP_PAGE_REG = 5'h00;
    localparam int SCP_PAGE_LSB = 8;
    localparam logic [15:0] SCP_REG_RESET = 16'h0000;

    // apb register offsets
    localparam logic [11:0] SCP_OFS_CTRL = 12'h000;
    localparam logic [11:0] SCP_OFS_STATUS = 12'h004;
    localparam logic [11:0] SCP_OFS_FRAMES = 12'h008;

    // apb register fields and reset values
    localparam int SCP_CTRL_PORT_EN_BIT = 0;
    localparam logic SCP_CTRL_PORT_EN_RESET = 1'b1;
    localparam int SCP_STS_BUSY_BIT = 0;
    localparam int SCP_STS_HDR_ERR_BIT = 1;
    localparam int SCP_STS_CHIP_EN_BIT = 2;
    localparam int SCP_STS_ADDR_LSB = 8;
    localparam int SCP_STS_PAGE_LSB = 16;

    // serial port states
    typedef enum logic [3:0]
    {
        SCP_ST_IDLE = 4'h1,
        SCP_ST_SHIFT = 4'h2,
        SCP_ST_TURN = 4'h4,
        SCP_ST_SEND = 4'h8
    } scp_state_t;

endpackage

// ---- core/scp_sync.sv ----
// two flip-flop synchroniser for pins from outside the clock domain
// assumes the inputs are levels that stay put for several clocks
`timescale 1ns/1ps
module scp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } scp_sync_t;

    scp_sync_t q;
    scp_sync_t d;

    if (W < 1)
    begin : g_chk
        $error("scp_sync: width must be at least one");
    end

    // first stage feeds only the second
    always_comb
    begin
        d.s1 = din;
        d.s2 = q.s1;
    end

    // synchronous reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign dout = q.s2;
endmodule

// ---- core/scp_reg_array.sv ----
// paged control register storage, flip-flops addressed by an index
// assumes one write per clock; read is combinational from the index
`timescale 1ns/1ps
module scp_reg_array
    import scp_pkg::*;
#(
    parameter int PAGES = SCP_PAGES,
    parameter int REGS = SCP_REGS_PER_PAGE,
    parameter int WIDTH = SCP_REG_WIDTH,
    localparam int IDX_W = $clog2(PAGES * REGS),
    localparam int PG_W = $clog2(PAGES)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data,
    output logic [PG_W-1:0] page
);
    typedef struct packed {
        logic [PAGES*REGS-1:0][WIDTH-1:0] mem;
    } scp_array_t;

    scp_array_t q;
    scp_array_t d;

    if (PAGES != 4 || REGS != 32 || WIDTH != 16)
    begin : g_chk
        $error("scp_reg_array: geometry must be 4 pages of 32 x 16 bits");
    end

    // write port
    always_comb
    begin
        d = q;
        if (wr_en)
        begin
            d.mem[wr_idx] = wr_data; // RQ6
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '{mem: '{default: SCP_REG_RESET}};
        end
        else
        begin
            q <= d;
        end
    end

    // read port and active page from the shared register 0
    assign rd_data = q.mem[rd_idx];
    assign page = q.mem[0][SCP_PAGE_LSB +: PG_W]; // RQ7
endmodule

// ---- verification/scp_monitor.sv ----
// checker for apb answer timing and data line turnaround
// assumes binding to scp_serial_port, seeing only its ports
`timescale 1ns/1ps
module scp_monitor #(
    parameter int APB_AW = 12
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [APB_AW-1:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic CTRL_SERIAL_CLOCK,
    input wire logic CTRL_LOAD_STROBE,
    input wire logic CTRL_SERIAL_DATA_O,
    input wire logic CTRL_SERIAL_DATA_OE
);
    logic [3:0] since_rise_q;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // clocks since the serial clock pin last rose, saturating
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            since_rise_q <= 4'hF;
        else if ($rose(CTRL_SERIAL_CLOCK))
            since_rise_q <= 4'h0;
        else if (since_rise_q != 4'hF)
            since_rise_q <= since_rise_q + 4'h1;
    end
    // apb setup then first access cycle
    sequence apb_setup_s;
        PSEL && !PENABLE ##1 PSEL && PENABLE;
    endsequence
    // shortly after a serial clock rise
    sequence near_rise_s;
        since_rise_q <= 4'h5;
    endsequence
    wait_state_a: assert property (apb_setup_s |-> !PREADY ##1 PREADY)
        else $error("apb answer not after one wait state");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (PREADY && PADDR > 12'h008 |-> PSLVERR)
        else $error("unmapped address not refused");
    mapped_ok_a: assert property (PREADY && PADDR inside {12'h000, 12'h004, 12'h008} |-> !PSLVERR)
        else $error("mapped address refused");
    oe_timing_a: assert property ($changed(CTRL_SERIAL_DATA_OE) |-> near_rise_s)
        else $error("data enable moved away from a serial rise");
    data_timing_a: assert property (CTRL_SERIAL_DATA_OE && $changed(CTRL_SERIAL_DATA_O) |-> near_rise_s)
        else $error("read data moved away from a serial rise");
    drive_hold_a: assert property (CTRL_SERIAL_DATA_OE && !CTRL_LOAD_STROBE |=> CTRL_SERIAL_DATA_OE)
        else $error("data line dropped without strobe");
    release_cause_a: assert property ($fell(CTRL_SERIAL_DATA_OE) |-> CTRL_LOAD_STROBE)
        else $error("data line released with strobe low");
    release_bound_a: assert property ($rose(CTRL_LOAD_STROBE) && CTRL_SERIAL_DATA_OE |-> ##[1:12] !CTRL_SERIAL_DATA_OE)
        else $error("data line not released after strobe");
endmodule
bind scp_serial_port scp_monitor #(.APB_AW(APB_AW)) mon_u (
    .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CTRL_SERIAL_CLOCK(CTRL_SERIAL_CLOCK),
    .CTRL_LOAD_STROBE(CTRL_LOAD_STROBE), .CTRL_SERIAL_DATA_O(CTRL_SERIAL_DATA_O),
    .CTRL_SERIAL_DATA_OE(CTRL_SERIAL_DATA_OE));

// ---- verification/scp_master_model.sv ----
// serial master model: clock, strobe and data line, 160 ns bits
// assumes the device output settles within three system clocks of a rise
`timescale 1ns/1ps
module scp_master_model (
    input wire logic clk,
    output logic sck,
    output logic stb,
    output logic line,
    input wire logic dout,
    input wire logic doe
);
    logic m_oe;
    logic m_val;
    logic last_q = 1'b0;
    // remember the last driven level; a released line shows its inverse
    always @(posedge clk)
    begin
        if (doe || m_oe)
        begin
            last_q <= line;
        end
    end
    // resolved wire; both driving gives unknown
    assign line = (doe && m_oe) ? 1'bX : (doe ? dout : (m_oe ? m_val : ~last_q));
    initial
    begin
        sck = 1'b0;
        stb = 1'b0;
        m_oe = 1'b1;
        m_val = 1'b0;
    end
    // one frame msb first; half a serial period is four system clocks
    // reads return 17 samples, the last one the held bit
    task automatic xfer(input logic [24:0] f, output logic [16:0] rd);
        int n;
        n = f[21] ? 9 : 25;
        rd = 17'h0;
        @(posedge clk);
        for (int i = 24; i > 24 - n; i--)
        begin
            m_val <= f[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
        if (f[21])
        begin
            m_oe <= 1'b0;
            for (int i = 0; i < 17; i++)
            begin
                repeat (4) @(posedge clk);
                sck <= 1'b1;
                repeat (4) @(posedge clk);
                rd = {rd[15:0], line};
                sck <= 1'b0;
            end
        end
        stb <= 1'b1;
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        repeat (4) @(posedge clk);
        sck <= 1'b0;
        m_oe <= 1'b1;
        stb <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ---- verification/tb_serial_ctrl_register_port.sv ----
// self-checking bench for the serial control register port
// assumes scp_master_model on the serial side and the bound checker
`timescale 1ns/1ps
module tb_serial_ctrl_register_port;
    import scp_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sck, stb, din, dout, doe;
    logic chip_en = 1'b0;
    logic port_on = 1'b1;
    logic [1:0] page = 2'h0;
    logic [31:0] seed = 32'hD999;
    logic [15:0] mem [128];
    int frames = 0;
    int mismatches = 0;
    int checked = 0;
    // system clock
    always #10 mclk = ~mclk;
    scp_serial_port dut_u (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CTRL_SERIAL_CLOCK(sck), .CTRL_LOAD_STROBE(stb),
        .CTRL_SERIAL_DATA_I(din), .CTRL_SERIAL_DATA_O(dout), .CTRL_SERIAL_DATA_OE(doe),
        .CHIP_ENABLE(chip_en));
    scp_master_model m_u (.clk(mclk), .sck(sck), .stb(stb), .line(din), .dout(dout),
        .doe(doe));
    // xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // storage slot; address 0 is shared by all pages
    function automatic logic [6:0] idx(input logic [4:0] a);
        return (a == SCP_PAGE_REG) ? 7'h00 : {page, a};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // write frame with a chosen header, tracking expected storage
    task automatic sw(input logic [2:0] h, input logic [4:0] a, input logic [15:0] d);
        logic [16:0] rd;
        m_u.xfer({h, 1'b0, a, d}, rd);
        if (h == SCP_HEADER && port_on)
        begin
            frames++;
            mem[idx(a)] = d;
            if (a == SCP_PAGE_REG)
                page = d[9:8];
        end
    endtask
    task automatic sr(input logic [4:0] a);
        logic [16:0] rd;
        logic [15:0] e;
        m_u.xfer({SCP_HEADER, 1'b1, a, 16'h0000}, rd);
        frames++;
        e = mem[idx(a)];
        check({16'h0, rd[16:1]}, {16'h0, e});
        check({31'h0, rd[0]}, {31'h0, e[0]});
    endtask
    initial
    begin
        repeat (30000) @(posedge mclk);
        mismatches++;
        final_report();
    end
    initial
    begin
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 128; i++)
            mem[i] = SCP_REG_RESET;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(1'b0, SCP_OFS_CTRL, 32'h0, r, e);
        check(r, 32'h1);
        apb(1'b0, 12'h00C, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        $display("test reset done");
        sw(SCP_HEADER, 5'h00, 16'h0300);
        sw(SCP_HEADER, 5'h1F, 16'hA5C3);
        sw(SCP_HEADER, 5'h00, 16'h0C00);
        sr(5'h1F);
        sw(SCP_HEADER, 5'h00, 16'h0F00);
        sr(5'h1F);
        sr(5'h00);
        $display("test pages done");
        for (int i = 0; i < 12; i++)
        begin
            r = rnd();
            sw(SCP_HEADER, r[20:16], r[15:0]);
            sr(r[20:16]);
            sr(r[28:24]);
        end
        $display("test random done");
        sw(3'h4, 5'h02, 16'h5AA5);
        sr(5'h02);
        chip_en <= 1'b1;
        apb(1'b0, SCP_OFS_STATUS, 32'h0, r, e);
        check({30'h0, r[2:1]}, 32'h3);
        apb(1'b1, SCP_OFS_STATUS, 32'h2, r, e);
        apb(1'b0, SCP_OFS_STATUS, 32'h0, r, e);
        check({31'h0, r[1]}, 32'h0);
        apb(1'b1, SCP_OFS_CTRL, 32'h0, r, e);
        port_on = 1'b0;
        sw(SCP_HEADER, 5'h03, 16'h1234);
        apb(1'b1, SCP_OFS_CTRL, 32'h1, r, e);
        port_on = 1'b1;
        sr(5'h03);
        apb(1'b0, SCP_OFS_FRAMES, 32'h0, r, e);
        check({16'h0, r[15:0]}, frames);
        $display("test refusals done");
        final_report();
    end
endmodule
